// ### hdl/pfh_pkg.sv
package pfh_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W       = 22;
  localparam int DATA_W       = 16;
  localparam int BANK_ADDR_LSB = 20;

  // ==========================================================
  // pin timing, in ns, as specified
  localparam int CLK_PERIOD_NS          = 10;
  localparam int ADDRESS_ACCESS_TIME_NS = 70;
  localparam int WRITE_SETUP_NS         = 10;
  localparam int WRITE_PULSE_NS         = 35;
  localparam int WRITE_HOLD_NS          = 20;
  localparam int RESET_PULSE_MIN_NS     = 500;
  localparam int RESET_HIGH_TO_READ_NS  = 50;
  localparam int READY_WAIT_MAX_NS      = 20000;

  // ==========================================================
  // cycle counts; least times round up
  localparam int ACCESS_CYC      = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_SETUP_CYC = (WRITE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HOLD_CYC  = (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HIGH_CYC  = (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_WAIT_CYC  = READY_WAIT_MAX_NS / CLK_PERIOD_NS;

  // ==========================================================
  // data-pin enables (low = driven)
  localparam logic [15:0] DQ_DRIVE_WORD  = 16'h0000;
  localparam logic [15:0] DQ_DRIVE_BYTE  = 16'h7F00;
  localparam logic [15:0] DQ_READ_BYTE   = 16'h7FFF;
  localparam logic [15:0] DQ_RELEASE_ALL = 16'hFFFF;

endpackage

// ### hdl/pfh_flash_host.sv
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] command writes: write strobe and chip select low, output enable high
// [RULE2] device takes program data as bytes or words per width-select pin
// [RULE3] in unlock bypass a program needs two write cycles, not four
// [RULE4] device erases one sector, several sectors, or the whole array
// [RULE5] address space holds four banks chosen by upper address bits
// [RULE6] acceleration level enters bypass, unprotects sectors, speeds programming
// [RULE7] removing acceleration level restores normal operation and protection
// [RULE8] host applies acceleration only for programming; pin never left floating
// [RULE9] identification command makes reads return id codes on sixteen lines
// [RULE10] reads in one bank proceed while another bank programs or erases
// [RULE11] suspended erase allows access elsewhere in bank, not that sector
// [RULE12] chip select and reset high put device in standby, outputs off
// [RULE13] after standby, read data valid only after full chip-select access time
// [RULE14] deselecting during program or erase does not stop the operation
// [RULE15] stable address for access time plus 30 ns gives automatic sleep
// [RULE16] reset low long enough aborts work, tristates, ignores commands
// [RULE17] host reissues an operation that a reset interrupted
// [RULE18] reset during program or erase holds ready/busy low until recovered
// [RULE19] reset while idle completes within the non-embedded recovery time
// [RULE20] host waits reset-high recovery time before starting a read
// [RULE21] output enable high disables outputs and floats data pins
// [RULE22] bank one starts with eight small sectors, then large sectors
// [RULE23] after power-up or reset the device reads array with no command
// [RULE24] byte mode: low eight lines only, top data line is lowest address
// [RULE25] write cycle captured at earlier rise of write strobe or chip select
module pfh_flash_host (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // user request port
  input  wire logic                        reqValid,
  output logic                             reqReady,
  input  wire logic                        reqWrite,
  input  wire logic [pfh_pkg::ADDR_W-1:0]  reqAddr,
  input  wire logic                        reqLowAddr,
  input  wire logic [pfh_pkg::DATA_W-1:0]  reqData,
  input  wire logic                        byteMode,
  input  wire logic                        accelReq,
  input  wire logic                        protectReq,
  input  wire logic                        flashResetReq,
  // user answer port
  output logic                             rspValid,
  output logic [pfh_pkg::DATA_W-1:0]       rspData,
  output logic [1:0]                       rspBank,
  output logic                             hostBusy,
  // flash pins
  output logic [pfh_pkg::ADDR_W-1:0]       flashAddr,
  output logic                             flashCeN,
  output logic                             flashOeN,
  output logic                             flashWeN,
  output logic                             flashResetN,
  output logic                             flashWordMode,
  input  wire logic [pfh_pkg::DATA_W-1:0]  dqIn,
  output logic [pfh_pkg::DATA_W-1:0]       dqOut,
  output logic [pfh_pkg::DATA_W-1:0]       dqOeN,
  output logic                             accelLevelOn,
  output logic                             protectPinHigh,
  input  wire logic                        readyBusyN
);

  typedef enum logic [2:0] {
    ST_RST_PULSE, ST_RST_BUSY, ST_RST_RECOV, ST_IDLE,
    ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_RD_ACCESS
  } pfh_state_t;

  pfh_state_t  state_reg;
  pfh_state_t  stateNext;
  logic [15:0] timer_reg;
  logic [15:0] timerNext;
  logic        take;
  logic        wordModeNext;

  function automatic logic [15:0] loadOf(input int cycles);
    return 16'(cycles - 1);
  endfunction

  // ==========================================================
  // request handshake
  // reads are refused while the acceleration level is applied
  assign reqReady = (state_reg == ST_IDLE) && !flashResetReq &&
                    !(accelReq && !reqWrite);  // [RULE8]
  assign hostBusy = (state_reg != ST_IDLE);

  // ==========================================================
  // sequencer
  always_comb begin
    stateNext = state_reg;
    timerNext = (timer_reg == 16'h0000) ? 16'h0000 : timer_reg - 16'h0001;
    take      = 1'b0;
    unique case (state_reg)
      ST_RST_PULSE: if (timer_reg == 16'h0000) begin  // [RULE16]
        stateNext = ST_RST_BUSY;
        timerNext = loadOf(pfh_pkg::READY_WAIT_CYC);
      end
      // busy low means an aborted embedded operation is still unwinding
      ST_RST_BUSY: if (readyBusyN || timer_reg == 16'h0000) begin  // [RULE18] [RULE19]
        stateNext = ST_RST_RECOV;
        timerNext = loadOf(pfh_pkg::RESET_HIGH_CYC);
      end
      ST_RST_RECOV: if (timer_reg == 16'h0000) begin  // [RULE20]
        stateNext = ST_IDLE;  // [RULE23]
      end
      // device reset only starts from idle, so no host operation is ever cut short
      ST_IDLE: if (flashResetReq) begin  // [RULE17]
        stateNext = ST_RST_PULSE;
        timerNext = loadOf(pfh_pkg::RESET_PULSE_CYC);
      end else if (reqValid && reqReady) begin
        take = 1'b1;
        if (reqWrite) begin
          stateNext = ST_WR_SETUP;
          timerNext = loadOf(pfh_pkg::WRITE_SETUP_CYC);
        end else begin
          stateNext = ST_RD_ACCESS;
          timerNext = loadOf(pfh_pkg::ACCESS_CYC);  // [RULE13]
        end
      end
      ST_WR_SETUP: if (timer_reg == 16'h0000) begin
        stateNext = ST_WR_PULSE;
        timerNext = loadOf(pfh_pkg::WRITE_PULSE_CYC);
      end
      ST_WR_PULSE: if (timer_reg == 16'h0000) begin
        stateNext = ST_WR_HOLD;
        timerNext = loadOf(pfh_pkg::WRITE_HOLD_CYC);
      end
      ST_WR_HOLD: if (timer_reg == 16'h0000) begin
        stateNext = ST_IDLE;
      end
      ST_RD_ACCESS: if (timer_reg == 16'h0000) begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RST_PULSE;
      timer_reg <= 16'(pfh_pkg::RESET_PULSE_CYC - 1);
    end else begin
      state_reg <= stateNext;
      timer_reg <= timerNext;
    end
  end

  // ==========================================================
  // control pins, registered from the next state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flashResetN <= 1'b0;
      flashCeN    <= 1'b1;
      flashOeN    <= 1'b1;
      flashWeN    <= 1'b1;
    end else begin
      flashResetN <= (stateNext != ST_RST_PULSE);  // [RULE16]
      // idle keeps select high so the device sits in standby
      flashCeN    <= !(stateNext inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
                                         ST_RD_ACCESS});  // [RULE12]
      flashOeN    <= (stateNext != ST_RD_ACCESS);  // [RULE1] [RULE21]
      // strobe rises before select, so its rise is the capture edge
      flashWeN    <= (stateNext != ST_WR_PULSE);  // [RULE1] [RULE25]
    end
  end

  // ==========================================================
  // address, data and width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flashAddr     <= '0;
      dqOut         <= '0;
      flashWordMode <= 1'b1;
      rspBank       <= 2'h0;
    end else if (take) begin
      flashAddr     <= reqAddr;
      flashWordMode <= !byteMode;  // [RULE2]
      rspBank       <= reqAddr[pfh_pkg::BANK_ADDR_LSB +: 2];  // [RULE5]
      if (byteMode) begin
        dqOut <= {reqLowAddr, 7'h00, reqData[7:0]};  // [RULE24]
      end else begin
        dqOut <= reqData;
      end
    end
  end

  // width of the request being taken, so lanes match from the first bus cycle
  assign wordModeNext = take ? !byteMode : flashWordMode;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dqOeN <= pfh_pkg::DQ_RELEASE_ALL;
    end else if (stateNext inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD}) begin
      dqOeN <= wordModeNext ? pfh_pkg::DQ_DRIVE_WORD : pfh_pkg::DQ_DRIVE_BYTE;  // [RULE24]
    end else if (stateNext == ST_RD_ACCESS && !wordModeNext) begin
      dqOeN <= pfh_pkg::DQ_READ_BYTE;  // [RULE24]
    end else begin
      dqOeN <= pfh_pkg::DQ_RELEASE_ALL;  // [RULE21]
    end
  end

  // ==========================================================
  // protect/accelerate pin, always driven to a defined level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accelLevelOn   <= 1'b0;
      protectPinHigh <= 1'b1;
    end else begin
      accelLevelOn   <= accelReq && (stateNext != ST_RD_ACCESS) &&
                        (stateNext != ST_RST_PULSE);  // [RULE8]
      protectPinHigh <= !protectReq;  // [RULE8]
    end
  end

  // ==========================================================
  // read answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData  <= '0;
    end else begin
      rspValid <= (state_reg == ST_RD_ACCESS) && (timer_reg == 16'h0000);  // [RULE13]
      if (state_reg == ST_RD_ACCESS && timer_reg == 16'h0000) begin
        rspData <= flashWordMode ? dqIn : {8'h00, dqIn[7:0]};  // [RULE24]
      end
    end
  end

  // ==========================================================
  // checks
  logic [15:0] rdCnt_reg;
  logic [15:0] rstLowCnt_reg;
  logic [15:0] sinceRst_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdCnt_reg     <= 16'h0000;
      rstLowCnt_reg <= 16'h0000;
      sinceRst_reg  <= 16'h0000;
    end else begin
      rdCnt_reg     <= flashOeN ? 16'h0000 : rdCnt_reg + 16'h0001;
      rstLowCnt_reg <= flashResetN ? 16'h0000 : rstLowCnt_reg + 16'h0001;
      if (!flashResetN) begin
        sinceRst_reg <= 16'h0000;
      end else if (sinceRst_reg != 16'hFFFF) begin
        sinceRst_reg <= sinceRst_reg + 16'h0001;
      end
    end
  end

  a_write_levels: assert property ( // [RULE1]
    @(posedge clk) disable iff (rst) !flashWeN |-> !flashCeN && flashOeN)
    else $error("write strobe low without select low and output enable high");
  a_write_pulse: assert property ( // [RULE1]
    @(posedge clk) disable iff (rst) $fell(flashWeN) |-> !flashWeN [*4] ##1 flashWeN)
    else $error("write strobe low time wrong");
  a_capture_edge: assert property ( // [RULE25]
    @(posedge clk) disable iff (rst)
    $rose(flashWeN) |-> !flashCeN && flashAddr == $past(flashAddr) && dqOut == $past(dqOut))
    else $error("select or bus moved at write capture edge");
  a_read_access: assert property ( // [RULE13]
    @(posedge clk) disable iff (rst) rspValid |-> rdCnt_reg >= 16'(pfh_pkg::ACCESS_CYC))
    else $error("read data taken before access time");
  a_reset_width: assert property ( // [RULE16]
    @(posedge clk) disable iff (rst)
    $rose(flashResetN) |-> rstLowCnt_reg >= 16'(pfh_pkg::RESET_PULSE_CYC))
    else $error("reset pulse shorter than minimum");
  a_reset_quiet: assert property ( // [RULE16]
    @(posedge clk) disable iff (rst) !flashResetN |-> flashCeN && flashWeN && !reqReady)
    else $error("bus activity during device reset");
  a_read_recovery: assert property ( // [RULE20]
    @(posedge clk) disable iff (rst)
    !flashOeN |-> sinceRst_reg >= 16'(pfh_pkg::RESET_HIGH_CYC))
    else $error("read started inside reset recovery");
  a_output_disable: assert property ( // [RULE21]
    @(posedge clk) disable iff (rst) !flashOeN |-> dqOeN[14:0] == 15'h7FFF)
    else $error("data lines driven while device drives them");
  a_byte_lanes: assert property ( // [RULE24]
    @(posedge clk) disable iff (rst) !flashWordMode |-> dqOeN[14:8] == 7'h7F)
    else $error("upper data lines driven in byte mode");
  a_accel_use: assert property ( // [RULE8]
    @(posedge clk) disable iff (rst) accelLevelOn |-> flashOeN && flashResetN)
    else $error("acceleration level applied outside programming");
  a_idle_standby: assert property ( // [RULE12]
    @(posedge clk) disable iff (rst) (state_reg == ST_IDLE) |-> flashCeN && flashResetN)
    else $error("idle without standby levels");

endmodule

// ### verif/pfh_flash_dev.sv
`timescale 1ns/1ns
// ==========================================================
// behavioural flash device, small aliased array
module pfh_flash_dev #(
  parameter int READY_DLY = 40
) (
  // pins
  input  wire logic        clk,
  input  wire logic [21:0] addr,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        resetN,
  input  wire logic        wordMode,
  input  wire logic [15:0] hostDq,
  input  wire logic [15:0] hostOeN,
  // resolved wire and status
  output logic [15:0]      dqWire,
  output logic             readyBusyN
);
  logic [15:0] mem [256];
  logic [15:0] lastDq;
  logic [15:0] rdWord;
  logic        devOn;
  int          busyCnt;

  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    lastDq = 16'h0000;
  end
  assign devOn = !ceN && !oeN && resetN;
  // byte mode picks a lane by the low address on the top data line
  assign rdWord = wordMode ? mem[addr[7:0]] :
                  {8'h00, hostDq[15] ? mem[addr[7:0]][15:8] : mem[addr[7:0]][7:0]};
  // released lines flip each cycle so a stale value never passes
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!hostOeN[i]) dqWire[i] = hostDq[i];
      else if (devOn && (wordMode || i < 8)) dqWire[i] = rdWord[i];
      else dqWire[i] = ~lastDq[i];
    end
  end
  always @(posedge clk) lastDq <= dqWire;
  always @(posedge weN) begin
    if (!ceN && oeN && resetN) begin
      if (wordMode) mem[addr[7:0]] = hostDq;
      else if (hostDq[15]) mem[addr[7:0]][15:8] = hostDq[7:0];
      else mem[addr[7:0]][7:0] = hostDq[7:0];
    end
  end
  always @(posedge clk or negedge resetN) begin
    if (!resetN) busyCnt <= READY_DLY;
    else if (busyCnt > 0) busyCnt <= busyCnt - 1;
  end
  assign readyBusyN = (busyCnt == 0);
endmodule

// ### verif/pfh_flash_host_tb_top.sv
`timescale 1ns/1ns
module pfh_flash_host_tb_top;
  // ==========================================================
  // signals
  logic        clk, rst, reqValid, reqWrite, reqLowAddr, byteMode;
  logic        accelReq, protectReq, flashResetReq, reqReady, rspValid, hostBusy;
  logic        flashCeN, flashOeN, flashWeN, flashResetN, flashWordMode;
  logic        accelLevelOn, protectPinHigh, readyBusyN;
  logic [21:0] reqAddr, flashAddr;
  logic [15:0] reqData, rspData, dqOut, dqOeN, dqWire;
  logic [1:0]  rspBank;
  int          miscompares = 0;
  int          checked = 0;

  pfh_flash_host u_pfh_flash_host (.clk, .rst, .reqValid, .reqReady, .reqWrite, .reqAddr,
    .reqLowAddr, .reqData, .byteMode, .accelReq, .protectReq, .flashResetReq, .rspValid,
    .rspData, .rspBank, .hostBusy, .flashAddr, .flashCeN, .flashOeN, .flashWeN,
    .flashResetN, .flashWordMode, .dqIn(dqWire), .dqOut, .dqOeN, .accelLevelOn,
    .protectPinHigh, .readyBusyN);
  pfh_flash_dev u_pfh_flash_dev (.clk, .addr(flashAddr), .ceN(flashCeN), .oeN(flashOeN),
    .weN(flashWeN), .resetN(flashResetN), .wordMode(flashWordMode), .hostDq(dqOut),
    .hostOeN(dqOeN), .dqWire, .readyBusyN);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic step(inout int n);
    @(posedge clk);
    #1;
    n++;
  endtask
  task automatic cmp_bit(string name, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cmp_word(string name, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic issue(logic wr, logic [21:0] a, logic [15:0] d, logic bm, logic la);
    int n = 0;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    byteMode = bm;
    reqLowAddr = la;
    while (reqReady !== 1'b1 && n < 3000) step(n);
    cmp_bit("reqTaken", 1'b1, reqReady);
    step(n);
    reqValid = 1'b0;
  endtask
  task automatic wr(logic [21:0] a, logic [15:0] d, logic bm, logic la);
    int n = 0;
    issue(1'b1, a, d, bm, la);
    repeat (2) step(n);
    cmp_bit("weN", 1'b0, flashWeN);
    cmp_bit("ceN", 1'b0, flashCeN);
    cmp_bit("oeN", 1'b1, flashOeN);
    cmp_bit("wordMode", !bm, flashWordMode);
    cmp_bit("hostBusy", 1'b1, hostBusy);
  endtask
  task automatic rd(logic [21:0] a, logic bm, logic la, logic [15:0] exp);
    int n = 0;
    issue(1'b0, a, 16'h0000, bm, la);
    repeat (2) step(n);
    cmp_word("dqOeN", bm ? 16'h7FFF : 16'hFFFF, dqOeN);
    while (rspValid !== 1'b1 && n < 20) step(n);
    cmp_bit("rspValid", 1'b1, rspValid);
    cmp_bit("accessCyc", 1'b1, n == pfh_pkg::ACCESS_CYC);
    cmp_word("rspData", exp, rspData);
    cmp_bit("bank", a[21] == rspBank[1] && a[20] == rspBank[0], 1'b1);
  endtask

  // ==========================================================
  // scenarios
  task automatic s_words;
    rd(22'h000010, 1'b0, 1'b0, 16'hFFFF);
    wr(22'h000010, 16'hA55A, 1'b0, 1'b0);
    wr(22'h300020, 16'h1234, 1'b0, 1'b0);
    rd(22'h000010, 1'b0, 1'b0, 16'hA55A);
    rd(22'h300020, 1'b0, 1'b0, 16'h1234);
  endtask
  task automatic s_bytes;
    wr(22'h100030, 16'h00C3, 1'b1, 1'b1);
    rd(22'h100030, 1'b0, 1'b0, 16'hC3FF);
    rd(22'h100030, 1'b1, 1'b1, 16'h00C3);
    rd(22'h100030, 1'b1, 1'b0, 16'h00FF);
  endtask
  task automatic s_pins;
    int n = 0;
    accelReq = 1'b1;
    protectReq = 1'b1;
    reqWrite = 1'b0;
    repeat (3) step(n);
    cmp_bit("accel", 1'b1, accelLevelOn);
    cmp_bit("protect", 1'b0, protectPinHigh);
    cmp_bit("readRefused", 1'b0, reqReady);
    cmp_bit("ceIdle", 1'b1, flashCeN);
    wr(22'h200040, 16'h5AA5, 1'b0, 1'b0);
    accelReq = 1'b0;
    protectReq = 1'b0;
    repeat (3) step(n);
    cmp_bit("accel", 1'b0, accelLevelOn);
    cmp_bit("protect", 1'b1, protectPinHigh);
    rd(22'h200040, 1'b0, 1'b0, 16'h5AA5);
  endtask
  task automatic s_flash_reset;
    int n = 0;
    int m = 0;
    flashResetReq = 1'b1;
    while (flashResetN !== 1'b0 && n < 50) step(n);
    flashResetReq = 1'b0;
    cmp_word("dqOeN", 16'hFFFF, dqOeN);
    n = 0;
    while (flashResetN !== 1'b1 && n < 3000) step(n);
    cmp_bit("pulseLong", 1'b1, n == pfh_pkg::RESET_PULSE_CYC);
    while (reqReady !== 1'b1 && m < 3000) step(m);
    cmp_bit("busyWait", 1'b1, m >= 40);
    rd(22'h000010, 1'b0, 1'b0, 16'hA55A);
  endtask

  // ==========================================================
  // run
  task automatic complete_run;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    {rst, reqValid, reqWrite, reqLowAddr, byteMode} = 5'h10;
    {accelReq, protectReq, flashResetReq} = 3'h0;
    reqAddr = 22'h000000;
    reqData = 16'h0000;
    repeat (16) @(posedge clk);
    #1;
    cmp_bit("resetN", 1'b0, flashResetN);
    rst = 1'b0;
    s_words();
    s_bytes();
    s_pins();
    s_flash_reset();
    complete_run();
  end
endmodule
